/* File: sac_defs.vh */
// constants for the step attenuator control port
`ifndef SAC_DEFS_VH
`define SAC_DEFS_VH
// register byte offsets
`define SAC_OFF_CTRL 12'h000
`define SAC_OFF_STAT 12'h004
`define SAC_OFF_SHIFT 12'h008
// control register fields
`define SAC_CTRL_SERIAL 0
`define SAC_CTRL_STROBE 1
`define SAC_CTRL_PRESET 2
`define SAC_CTRL_DATA 3
`define SAC_CTRL_SCLK 4
`define SAC_CTRL_PAR_LO 8
`define SAC_CTRL_PAR_HI 12
`define SAC_CTRL_RESET 32'h0000_0000
// attenuation words
`define SAC_ATT_REF 5'h00
`define SAC_ATT_8DB 5'h10
`define SAC_WORD_W 5
`define SAC_SHIFT_W 6
// start-up count: edge on which synchronised pins are trusted
`define SAC_START_LAST 2'h2
// axi responses
`define SAC_RESP_OK 2'h0
`define SAC_RESP_SLVERR 2'h2
`endif

/* File: sac_step_atten_ctrl.v */
// control logic of a 5-bit step attenuator with axi4-lite access
//
// Function
// - select low parallel, high serial
// - five parallel bits give 32 states
// - strobe high makes parallel bits direct
// - six-bit shift register, transparent latch
// - shifting ignores the strobe level
// - strobe high: latch follows shift register
// - strobe fall holds shift register value
// - serial powerup loads parallel bits
// - parallel powerup strobe low uses preset
// - parallel powerup strobe high follows bits
// - bit weights 8,4,2,1,0.5 dB
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "sac_defs.vh"
module sac_step_atten_ctrl (
   // clock and reset
   input wire sys_clk,
   input wire resetn,
   // axi4-lite write address
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // control pins from the controller
   input wire interfaceSelect,
   input wire wordCommitStrobe,
   input wire powerupPresetSelect,
   input wire serialData,
   input wire serialClock,
   input wire eightDbBit,
   input wire fourDbBit,
   input wire twoDbBit,
   input wire oneDbBit,
   input wire halfDbBit,
   // attenuation word, bit 4 is 8 dB down to bit 0 at 0.5 dB
   output reg [4:0] attenWord
);

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
// pins are ored with the software overrides so either can drive
reg [31:0] ctrl;
wire [9:0] pinRaw;
reg [9:0] pinMeta;
reg [9:0] pinSync;
assign pinRaw = {eightDbBit, fourDbBit, twoDbBit, oneDbBit, halfDbBit,
   serialClock, serialData, powerupPresetSelect, wordCommitStrobe,
   interfaceSelect};
always @(posedge sys_clk or negedge resetn) begin
   if (!resetn) begin
      pinMeta <= 10'h000;
      pinSync <= 10'h000;
   end else begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
   end
end
wire selSerial = pinSync[0] | ctrl[`SAC_CTRL_SERIAL];
wire strobe = pinSync[1] | ctrl[`SAC_CTRL_STROBE];
wire presetSel = pinSync[2] | ctrl[`SAC_CTRL_PRESET];
wire sData = pinSync[3] | ctrl[`SAC_CTRL_DATA];
wire sClk = pinSync[4] | ctrl[`SAC_CTRL_SCLK];
// parallel bits, msb is the 8 dB weight
wire [4:0] parWord = pinSync[9:5] |
   ctrl[`SAC_CTRL_PAR_HI:`SAC_CTRL_PAR_LO];

// ----------------------------------------
// serial shift register
// ----------------------------------------
reg sClkLast;
reg [5:0] shiftReg;
wire sClkRise = sClk & ~sClkLast;
always @(posedge sys_clk or negedge resetn) begin
   if (!resetn) begin
      sClkLast <= 1'b0;
      shiftReg <= 6'h00;
   end else begin
      sClkLast <= sClk;
      if (sClkRise) begin
         shiftReg <= {shiftReg[4:0], sData};
      end
   end
end

// ----------------------------------------
// power-up preset and output latch
// ----------------------------------------
// inputs are only valid once synchronised, so wait two edges
reg [1:0] startCnt;
reg started;
always @(posedge sys_clk or negedge resetn) begin
   if (!resetn) begin
      startCnt <= 2'h0;
      started <= 1'b0;
      attenWord <= `SAC_ATT_REF;
   end else if (!started) begin
      startCnt <= startCnt + 2'h1;
      if (startCnt == `SAC_START_LAST) begin
         started <= 1'b1;
         if (selSerial) begin
            attenWord <= parWord;
         end else if (strobe) begin
            attenWord <= parWord;
         end else if (presetSel) begin
            attenWord <= `SAC_ATT_8DB;
         end else begin
            attenWord <= `SAC_ATT_REF;
         end
      end
   end else if (strobe) begin
      // pad bit dropped; a set pad bit is the controller's fault
      if (selSerial) begin
         attenWord <= shiftReg[4:0];
      end else begin
         attenWord <= parWord;
      end
   end
end

// ----------------------------------------
// axi4-lite write
// ----------------------------------------
reg awHeld;
reg wHeld;
reg [11:0] awAddr;
reg [31:0] wData;
reg [3:0] wStrb;
assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
assign s_axi_wready = ~wHeld & ~s_axi_bvalid;
wire [11:0] curAw = awHeld ? awAddr : s_axi_awaddr;
wire [31:0] curW = wHeld ? wData : s_axi_wdata;
wire [3:0] curS = wHeld ? wStrb : s_axi_wstrb;
wire haveAw = awHeld | (s_axi_awvalid & s_axi_awready);
wire haveW = wHeld | (s_axi_wvalid & s_axi_wready);
wire doWrite = haveAw & haveW;
integer i;
always @(posedge sys_clk or negedge resetn) begin
   if (!resetn) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 12'h000;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SAC_RESP_OK;
      ctrl <= `SAC_CTRL_RESET;
   end else begin
      if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
      if (doWrite) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         s_axi_bvalid <= 1'b1;
         if (curAw[11:2] == `SAC_OFF_CTRL >> 2) begin
            s_axi_bresp <= `SAC_RESP_OK;
            for (i = 0; i < 4; i = i + 1) begin
               if (curS[i]) begin
                  ctrl[i*8 +: 8] <= curW[i*8 +: 8];
               end
            end
         end else if (curAw[11:2] == `SAC_OFF_STAT >> 2 ||
            curAw[11:2] == `SAC_OFF_SHIFT >> 2) begin
            s_axi_bresp <= `SAC_RESP_OK;
         end else begin
            s_axi_bresp <= `SAC_RESP_SLVERR;
         end
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
      end
   end
end

// ----------------------------------------
// axi4-lite read
// ----------------------------------------
assign s_axi_arready = ~s_axi_rvalid;
always @(posedge sys_clk or negedge resetn) begin
   if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SAC_RESP_OK;
   end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SAC_RESP_OK;
      if (s_axi_araddr[11:2] == `SAC_OFF_CTRL >> 2) begin
         s_axi_rdata <= ctrl;
      end else if (s_axi_araddr[11:2] == `SAC_OFF_STAT >> 2) begin
         s_axi_rdata <= {16'h0000, 3'h0, attenWord, 4'h0, started,
            strobe, selSerial, presetSel};
      end else if (s_axi_araddr[11:2] == `SAC_OFF_SHIFT >> 2) begin
         s_axi_rdata <= {26'h000_0000, shiftReg};
      end else begin
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SAC_RESP_SLVERR;
      end
   end
end

endmodule

/* File: sac_ctrl_sva.sv */
// checker for the attenuator control ports
`timescale 1ns/1ps
module sac_ctrl_sva (
   // clock and reset
   input wire sys_clk,
   input wire resetn,
   // bus handshakes
   input wire s_axi_awready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // pins and result
   input wire interfaceSelect,
   input wire wordCommitStrobe,
   input wire serialClock,
   input wire eightDbBit,
   input wire fourDbBit,
   input wire twoDbBit,
   input wire oneDbBit,
   input wire halfDbBit,
   input wire [4:0] attenWord
);
   // ---
   // properties
   // ---
   wire [4:0] pins = {eightDbBit, fourDbBit, twoDbBit, oneDbBit, halfDbBit};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
   a_rresp_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read answer dropped");
   a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken while busy");
   a_latch_hold: assert property (!wordCommitStrobe [*6] |-> $stable(attenWord))
      else $error("word moved with strobe low");
   a_direct_follow: assert property ((!interfaceSelect && wordCommitStrobe
      && $stable(pins)) [*6] |-> attenWord == pins)
      else $error("word not following pins");
   a_serial_still: assert property ((interfaceSelect && !serialClock
      && $stable(wordCommitStrobe)) [*6] |-> $stable(attenWord))
      else $error("serial word moved");
endmodule
bind sac_step_atten_ctrl sac_ctrl_sva chk (.*);

/* File: sac_ctrl_partner.sv */
// controller model driving the attenuator pins
`timescale 1ns/1ps
module sac_ctrl_partner (
   // pins
   output logic strobe,
   output logic sData,
   output logic sClk,
   output logic [4:0] bits
);
   initial begin
      strobe = 0;
      sData = 0;
      sClk = 0;
      bits = 0;
   end
   // link clock stands still outside frames
   task automatic sendSerial(input [4:0] w);
      #3 for (int i = 5; i >= 0; i--) begin
         sData = (i == 5) ? 1'b0 : w[i];
         #80 sClk = 1;
         #80 sClk = 0;
      end
      sData = ~w[0];
      #80 strobe = 1;
      #80 strobe = 0;
      #40000;
   endtask
   task automatic setPar(input [4:0] w, input direct);
      #3 bits = w;
      strobe = direct;
      if (!direct) begin
         #80 strobe = 1;
         #80 strobe = 0;
      end
      #40000;
   endtask
endmodule

/* File: testbench.sv */
// self-checking bench for the attenuator control block
`timescale 1ns/1ps
module testbench;
   logic sys_clk = 0;
   logic resetn = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic interfaceSelect = 0, powerupPresetSelect = 0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, wordCommitStrobe, serialData, serialClock;
   wire eightDbBit, fourDbBit, twoDbBit, oneDbBit, halfDbBit;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [4:0] attenWord;
   logic [33:0] readQ[$];
   logic [4:0] attQ[$];
   logic [4:0] w;
   int miscompares = 0, testsRun = 0, seed = 32'h11fe;
   sac_step_atten_ctrl uut (.*);
   sac_ctrl_partner ctl (.strobe(wordCommitStrobe), .sData(serialData),
      .sClk(serialClock),
      .bits({eightDbBit, fourDbBit, twoDbBit, oneDbBit, halfDbBit}));
   always #4 sys_clk = ~sys_clk;
   task automatic chk(input logic [33:0] got, exp);
      testsRun++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chkAtt(input logic [4:0] got, exp);
      chk({29'h0, got}, {29'h0, exp});
   endtask
   task automatic chkResp(input logic [1:0] got, exp);
      chk({32'h0, got}, {32'h0, exp});
   endtask
   task automatic print_verdict;
      if (miscompares == 0 && testsRun > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic giveUp;
      miscompares++;
      print_verdict;
   endtask
   always @(posedge sys_clk)
      if (s_axi_rvalid && s_axi_rready && readQ.size())
         chk({s_axi_rresp, s_axi_rdata}, readQ.pop_front());
   always @(attenWord)
      if (resetn && attQ.size()) chkAtt(attenWord, attQ.pop_front());
   // a leading edge keeps two transfers from touching one signal twice
   task automatic axWrite(input [11:0] a, input [31:0] d, input [1:0] e);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      for (int i = 0; i < 99; i++) begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_bvalid) begin
            chkResp(s_axi_bresp, e);
            s_axi_bready <= 0;
            return;
         end
      end
      giveUp;
   endtask
   task automatic axRead(input [11:0] a, input [33:0] e);
      @(posedge sys_clk);
      readQ.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      for (int i = 0; i < 99; i++) begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_rvalid) begin
            s_axi_rready <= 0;
            return;
         end
      end
      giveUp;
   endtask
   task automatic powerUp(input sel, dir, pre, input [4:0] b, e);
      interfaceSelect <= sel;
      powerupPresetSelect <= pre;
      ctl.setPar(b, dir);
      @(posedge sys_clk);
      resetn <= 0;
      repeat (10) @(posedge sys_clk);
      resetn <= 1;
      repeat (8) @(posedge sys_clk);
      chkAtt(attenWord, e);
   endtask
   // ---
   // scenarios
   // ---
   initial begin
      repeat (10) @(posedge sys_clk);
      resetn <= 1;
      powerUp(0, 1, 1, 5'h05, 5'h05);
      powerUp(0, 0, 1, 5'h0b, 5'h10);
      powerUp(0, 0, 0, 5'h0b, 5'h00);
      powerUp(1, 0, 0, 5'h0b, 5'h0b);
      interfaceSelect <= 0;
      for (int k = 0; k < 7; k++) begin
         w = $random(seed);
         if (w == attenWord) w = ~w;
         attQ.push_back(w);
         if (k == 4) interfaceSelect <= 1;
         if (k < 4) ctl.setPar(w, k < 2);
         else ctl.sendSerial(w);
         for (int i = 0; i < 99 && attQ.size(); i++) @(posedge sys_clk);
         if (attQ.size()) giveUp;
      end
      axRead(12'h008, {28'h0, 1'b0, w});
      axRead(12'h004, {21'h0, w, 8'h0a});
      axWrite(12'h000, 32'h0000_1508, 2'h0);
      axRead(12'h000, 34'h0_0000_1508);
      axWrite(12'h000, 32'h0, 2'h0);
      axWrite(12'h00c, 32'h0, 2'h2);
      axRead(12'h00c, {2'h2, 32'h0});
      repeat (2) @(posedge sys_clk);
      // results still owed count as misses
      if (readQ.size() || attQ.size()) miscompares++;
      print_verdict;
   end
endmodule
